// [rtl/adc_sequencer_control.sv]
/*
 * Control register bank and conversion sequencer around a 10-bit
 * successive-approximation core, reached over APB.
 * Assumes the analog core, power manager and event source run on the
 * same peripheral clock; core_done is a one-cycle pulse with data valid.
 */
// Decided for this implementation: the APB register port.
// Operation
// RULE1: standby_run bit 7 keeps the converter running during standby sleep
// RULE2: resolution bit clear keeps 10 bits, set keeps upper eight only
// RULE3: continuous mode starts on command, then each conversion follows at once
// RULE4: each completed continuous conversion sets the result-ready flag
// RULE5: accumulation codes 0 to 6 select 1 to 64 samples, 7 reserved
// RULE6: nonzero accumulation sums samples into result as one conversion
// RULE7: converter clock is peripheral clock divided by 2 to 256 by code
// RULE8: reference code selects internal, supply rail or external pin
// RULE9: capacitance bit 6 selects the reduced sampling capacitance
// RULE10: startup delay precedes first sample after enable or internal reference
// RULE11: startup code gives 0,16,32,64,128,256 converter clocks for codes 0-5
// RULE12: startup delay also applies when waking from deep sleep to measure
// RULE13: delay variation increments inter-sample delay after each sample, wrapping
// RULE14: wait inter-sample delay field converter clocks between samples
// RULE15: sampling capacitor stays open throughout every inter-sample delay
// RULE16: enable bit 0 switches converter on, reset leaves it off
// RULE17: start command reads one while converting, clears itself when done
// RULE18: flags clear by writing one or by reading result, zero does nothing
// RULE19: window mode selects none, below, above, inside or outside
// RULE20: each new result gives a result-ready event pulse of one clock
// RULE21: with enable clear, starts are ignored and sequencing stays idle
// RULE22: software must not program reserved accumulation, reference or delay codes
`timescale 1ns/1ns
`default_nettype none

module adc_sequencer_control
   import adc_seq_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system state
   input wire logic standby_sleep,
   input wire logic cpu_halted,
   input wire logic deep_sleep_wake,
   input wire logic start_event,
   // analog core
   output logic analog_enable,
   output logic [1:0] reference_select,
   output logic capacitance_select,
   output logic [4:0] input_select,
   output logic sample_active,
   output logic convert_start,
   input wire logic core_done,
   input wire logic [9:0] core_data,
   // event system
   output logic result_ready_event,
   output logic [1:0] irq_request
);

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   function automatic logic [6:0] samples_for(input logic [2:0] code);
      samples_for = 7'h01 << code; // [RULE5]
   endfunction : samples_for
   function automatic logic [7:0] divider_top(input logic [2:0] code);
      divider_top = 8'((9'h002 << code) - 9'h001); // [RULE7]
   endfunction : divider_top
   function automatic logic [8:0] startup_ticks(input logic [2:0] code);
      startup_ticks = (code == 3'h0) ? 9'h000 : 9'(9'h008 << code); // [RULE11]
   endfunction : startup_ticks
   function automatic logic window_hit(input logic [2:0] mode, input logic [15:0] v,
                                       input logic [15:0] lo, input logic [15:0] hi);
      case (mode) // [RULE19]
         WINDOW_BELOW: window_hit = v < lo;
         WINDOW_ABOVE: window_hit = v > hi;
         WINDOW_INSIDE: window_hit = (v > lo) && (v < hi);
         WINDOW_OUTSIDE: window_hit = (v < lo) || (v > hi);
         default: window_hit = 1'b0;
      endcase
   endfunction : window_hit
   function automatic logic [7:0] addr_of(input logic [5:0] idx);
      addr_of = {idx, 2'b00};
   endfunction : addr_of

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] control_enable_mode;
      logic [2:0] accumulation_count;
      logic [7:0] reference_clock_control;
      logic [7:0] delay_control;
      logic [2:0] window_mode;
      logic [4:0] sample_length;
      logic [4:0] input_select;
      logic start_conversion_cmd;
      logic event_start_enable;
      logic [1:0] irq_enable;
      logic [1:0] flags;
      logic run_when_halted;
      logic [7:0] staging;
      logic [15:0] result;
      logic [15:0] low_threshold;
      logic [15:0] high_threshold;
      logic clock_duty_adjust;
      phase_t phase;
      logic [7:0] clock_divider_cnt;
      logic tick;
      logic [8:0] wait_cnt;
      logic [6:0] samples_left;
      logic [15:0] accum;
      logic init_pending;
      logic enable_prev;
      logic event_prev;
      logic analog_on;
      logic sample_active;
      logic convert_start;
      logic result_event;
      logic [1:0] irq_out;
   } state_t;

   state_t s, next_s;

   // standby and debug halt freeze the sequencer unless told to keep going
   logic run_now;
   assign run_now = s.control_enable_mode[ENABLE_BIT] && (!cpu_halted || s.run_when_halted)
                    && (!standby_sleep || s.control_enable_mode[STANDBY_RUN_BIT]); // [RULE1]

   // ------------------------------------------------------------------
   // next-state logic: bus, flags and sequencer in one pass
   // ------------------------------------------------------------------
   always_comb begin
      logic access, wr_go, rd_go, enabled, run;
      logic [1:0] flag_set, flag_clr;
      logic [15:0] sample_val, sum;
      access = 1'b0;
      wr_go = 1'b0;
      rd_go = 1'b0;
      enabled = 1'b0;
      run = 1'b0;
      flag_set = 2'b00;
      flag_clr = 2'b00;
      sample_val = 16'h0000;
      sum = 16'h0000;
      next_s = s;
      next_s.convert_start = 1'b0;
      next_s.result_event = 1'b0;

      enabled = s.control_enable_mode[ENABLE_BIT]; // [RULE16]
      run = run_now; // [RULE1]

      // converter clock as a tick train; held at zero while disabled
      if (!enabled || s.clock_divider_cnt >= divider_top(s.reference_clock_control[2:0])) begin
         next_s.clock_divider_cnt = 8'h00;
         next_s.tick = enabled; // [RULE7]
      end else begin
         next_s.clock_divider_cnt = s.clock_divider_cnt + 8'h01;
         next_s.tick = 1'b0;
      end

      // apb: answer one cycle into the access phase
      access = psel && penable;
      wr_go = access && s.pready && pwrite;
      rd_go = access && s.pready && !pwrite;
      next_s.pready = access && !s.pready;
      if (access && !s.pready) begin
         next_s.pslverr = 1'b0;
         case (paddr)
            addr_of(IDX_CONTROL_ENABLE_MODE): next_s.prdata = {24'h0, s.control_enable_mode};
            addr_of(IDX_ACCUMULATION_CONTROL): next_s.prdata = {29'h0, s.accumulation_count};
            addr_of(IDX_REFERENCE_CLOCK_CONTROL): next_s.prdata = {24'h0, s.reference_clock_control};
            addr_of(IDX_DELAY_CONTROL): next_s.prdata = {24'h0, s.delay_control};
            addr_of(IDX_WINDOW_MODE_CONTROL): next_s.prdata = {29'h0, s.window_mode};
            addr_of(IDX_SAMPLE_LENGTH_CONTROL): next_s.prdata = {27'h0, s.sample_length};
            addr_of(IDX_INPUT_SELECT): next_s.prdata = {27'h0, s.input_select};
            addr_of(IDX_CONVERSION_COMMAND): next_s.prdata = {31'h0, s.start_conversion_cmd};
            addr_of(IDX_EVENT_INPUT_CONTROL): next_s.prdata = {31'h0, s.event_start_enable};
            addr_of(IDX_IRQ_ENABLE): next_s.prdata = {30'h0, s.irq_enable};
            addr_of(IDX_IRQ_FLAGS): next_s.prdata = {30'h0, s.flags};
            addr_of(IDX_HALT_BEHAVIOUR_CONTROL): next_s.prdata = {31'h0, s.run_when_halted};
            addr_of(IDX_WIDE_ACCESS_STAGING): next_s.prdata = {24'h0, s.staging};
            addr_of(IDX_CONVERSION_RESULT): next_s.prdata = {16'h0, s.result};
            addr_of(IDX_LOW_THRESHOLD): next_s.prdata = {16'h0, s.low_threshold};
            addr_of(IDX_HIGH_THRESHOLD): next_s.prdata = {16'h0, s.high_threshold};
            addr_of(IDX_CALIBRATION): next_s.prdata = {31'h0, s.clock_duty_adjust};
            default: begin
               next_s.prdata = 32'h0000_0000;
               next_s.pslverr = 1'b1;
            end
         endcase
      end else begin
         next_s.pslverr = 1'b0;
      end

      // reading the result clears both flags
      if (rd_go && paddr == addr_of(IDX_CONVERSION_RESULT)) begin
         flag_clr = 2'b11; // [RULE18]
      end

      // register writes take effect at the completing edge only
      if (wr_go) begin
         case (paddr)
            addr_of(IDX_CONTROL_ENABLE_MODE): next_s.control_enable_mode = pwdata[7:0] & 8'h87;
            addr_of(IDX_ACCUMULATION_CONTROL): next_s.accumulation_count = pwdata[2:0];
            addr_of(IDX_REFERENCE_CLOCK_CONTROL): begin
               next_s.reference_clock_control = pwdata[7:0] & 8'h77; // [RULE8] [RULE9]
               // switching to the internal reference needs settling time again
               if (pwdata[5:4] == REF_INTERNAL &&
                   s.reference_clock_control[5:4] != REF_INTERNAL) begin
                  next_s.init_pending = 1'b1; // [RULE10]
               end
            end
            addr_of(IDX_DELAY_CONTROL): next_s.delay_control = pwdata[7:0];
            addr_of(IDX_WINDOW_MODE_CONTROL): next_s.window_mode = pwdata[2:0];
            addr_of(IDX_SAMPLE_LENGTH_CONTROL): next_s.sample_length = pwdata[4:0];
            addr_of(IDX_INPUT_SELECT): next_s.input_select = pwdata[4:0];
            addr_of(IDX_CONVERSION_COMMAND): begin
               // writing zero never aborts; starts while disabled are dropped
               if (pwdata[0] && enabled) begin
                  next_s.start_conversion_cmd = 1'b1; // [RULE3] [RULE21]
               end
            end
            addr_of(IDX_EVENT_INPUT_CONTROL): next_s.event_start_enable = pwdata[0];
            addr_of(IDX_IRQ_ENABLE): next_s.irq_enable = pwdata[1:0];
            addr_of(IDX_IRQ_FLAGS): flag_clr = pwdata[1:0]; // [RULE18]
            addr_of(IDX_HALT_BEHAVIOUR_CONTROL): next_s.run_when_halted = pwdata[0];
            addr_of(IDX_WIDE_ACCESS_STAGING): next_s.staging = pwdata[7:0];
            addr_of(IDX_LOW_THRESHOLD): next_s.low_threshold = pwdata[15:0];
            addr_of(IDX_HIGH_THRESHOLD): next_s.high_threshold = pwdata[15:0];
            addr_of(IDX_CALIBRATION): next_s.clock_duty_adjust = pwdata[0];
            default: ;
         endcase
      end

      // rising edge of the trigger line starts a conversion when allowed
      next_s.event_prev = start_event;
      if (start_event && !s.event_prev && s.event_start_enable && run) begin
         next_s.start_conversion_cmd = 1'b1;
      end

      // power-up of the converter and deep-sleep wake both need the delay
      next_s.enable_prev = enabled;
      if ((enabled && !s.enable_prev) || deep_sleep_wake) begin
         next_s.init_pending = 1'b1; // [RULE10] [RULE12]
      end

      // sequencer
      if (!enabled) begin
         next_s.phase = IDLE; // [RULE21]
         next_s.start_conversion_cmd = 1'b0;
         next_s.sample_active = 1'b0;
      end else if (run) begin
         case (s.phase)
            IDLE: begin
               if (s.start_conversion_cmd) begin
                  next_s.accum = 16'h0000;
                  next_s.samples_left = samples_for(s.accumulation_count); // [RULE6]
                  if (s.init_pending) begin
                     next_s.init_pending = 1'b0;
                     next_s.wait_cnt = startup_ticks(s.delay_control[7:5]); // [RULE10]
                     next_s.phase = INIT_WAIT;
                  end else begin
                     next_s.wait_cnt = SAMPLE_BASE_CYCLES + 9'(s.sample_length);
                     next_s.phase = SAMPLING;
                     next_s.sample_active = 1'b1;
                  end
               end
            end
            INIT_WAIT, GAP_WAIT: begin
               // capacitor stays open while any delay runs
               next_s.sample_active = 1'b0; // [RULE15]
               if (s.wait_cnt == 9'h000) begin
                  next_s.wait_cnt = SAMPLE_BASE_CYCLES + 9'(s.sample_length);
                  next_s.phase = SAMPLING;
                  next_s.sample_active = 1'b1;
               end else if (s.tick) begin
                  next_s.wait_cnt = s.wait_cnt - 9'h001; // [RULE11] [RULE14]
               end
            end
            SAMPLING: begin
               if (s.tick) begin
                  if (s.wait_cnt == 9'h001) begin
                     next_s.sample_active = 1'b0;
                     next_s.convert_start = 1'b1;
                     next_s.phase = CONVERTING;
                  end else begin
                     next_s.wait_cnt = s.wait_cnt - 9'h001;
                  end
               end
            end
            CONVERTING: begin
               if (core_done) begin
                  // truncation happens before the sum, as the result format needs
                  sample_val = s.control_enable_mode[RESOLUTION_SELECT_BIT] ? // [RULE2]
                               {8'h00, core_data[9:2]} : {6'h00, core_data};
                  sum = s.accum + sample_val; // [RULE6]
                  if (s.delay_control[DELAY_VARIATION_BIT]) begin
                     next_s.delay_control[3:0] = s.delay_control[3:0] + 4'h1; // [RULE13]
                  end
                  next_s.wait_cnt = {5'h00, s.delay_control[3:0]}; // [RULE14]
                  next_s.phase = GAP_WAIT;
                  if (s.samples_left == 7'h01) begin
                     next_s.result = sum;
                     next_s.result_event = 1'b1; // [RULE20]
                     flag_set[RESULT_READY_BIT] = 1'b1; // [RULE4]
                     flag_set[WINDOW_MATCH_BIT] = window_hit(s.window_mode, sum,
                                                             s.low_threshold, s.high_threshold);
                     next_s.accum = 16'h0000;
                     next_s.samples_left = samples_for(s.accumulation_count);
                     if (!s.control_enable_mode[CONTINUOUS_MODE_BIT]) begin
                        next_s.start_conversion_cmd = 1'b0; // [RULE17]
                        next_s.phase = IDLE;
                     end
                  end else begin
                     next_s.accum = sum;
                     next_s.samples_left = s.samples_left - 7'h01;
                  end
               end
            end
            default: next_s.phase = IDLE;
         endcase
      end

      // a hardware set in the same cycle as a clear wins
      next_s.flags = (s.flags & ~flag_clr) | flag_set; // [RULE18]
      next_s.irq_out = next_s.flags & next_s.irq_enable; // registered, no glitch on the pin
      next_s.analog_on = run;
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state register
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign analog_enable = s.analog_on;
   assign reference_select = s.reference_clock_control[5:4]; // [RULE8]
   assign capacitance_select = s.reference_clock_control[CAPACITANCE_SELECT_BIT]; // [RULE9]
   assign input_select = s.input_select;
   assign sample_active = s.sample_active;
   assign convert_start = s.convert_start;
   assign result_ready_event = s.result_event;
   assign irq_request = s.irq_out;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   event_pulse_a: assert property (s.result_event |=> !s.result_event) // [RULE20]
      else $error("result event longer than one clock");
   ready_flag_a: assert property (s.result_event |-> s.flags[RESULT_READY_BIT]) // [RULE4]
      else $error("result ready flag not set with event");
   gap_open_a: assert property (s.phase == GAP_WAIT |-> !s.sample_active) // [RULE15]
      else $error("sampling during inter-sample delay");
   busy_cmd_a: assert property (s.phase != IDLE |-> s.start_conversion_cmd) // [RULE17]
      else $error("start command low while converting");
   disabled_idle_a: assert property (!s.control_enable_mode[ENABLE_BIT] |=> s.phase == IDLE) // [RULE21]
      else $error("sequencer left idle while disabled");
   tick_spacing_a: assert property (s.tick |=> !s.tick) // [RULE7]
      else $error("converter clock faster than half rate");
   narrow_result_a: assert property (s.phase == CONVERTING && core_done && run_now // [RULE2]
         && s.control_enable_mode[RESOLUTION_SELECT_BIT] && s.samples_left == 7'h01
         |=> s.result == $past(s.accum) + {8'h00, $past(core_data[9:2])})
      else $error("eight-bit result not truncated");
   delay_step_a: assert property (s.phase == CONVERTING && core_done && run_now // [RULE13]
         && s.delay_control[DELAY_VARIATION_BIT] && !(psel && penable && pwrite)
         |=> s.delay_control[3:0] == $past(s.delay_control[3:0]) + 4'h1)
      else $error("inter-sample delay not incremented");
   oneshot_end_a: assert property (s.result_event && !s.control_enable_mode[CONTINUOUS_MODE_BIT]
         && !$past(psel && penable && pwrite) |-> !s.start_conversion_cmd) // [RULE17]
      else $error("start command not cleared after conversion");

endmodule : adc_sequencer_control

`default_nettype wire

// [rtl/adc_seq_pkg.sv]
/*
 * Constants and types shared by the converter sequencing block: register
 * indices, field positions, reset values and codes, the phase type and timing.
 * Assumes a 32-bit APB bus with one register per aligned word.
 */
package adc_seq_pkg;

   // ------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [5:0] IDX_CONTROL_ENABLE_MODE = 6'h00;
   localparam logic [5:0] IDX_ACCUMULATION_CONTROL = 6'h01;
   localparam logic [5:0] IDX_REFERENCE_CLOCK_CONTROL = 6'h02;
   localparam logic [5:0] IDX_DELAY_CONTROL = 6'h03;
   localparam logic [5:0] IDX_WINDOW_MODE_CONTROL = 6'h04;
   localparam logic [5:0] IDX_SAMPLE_LENGTH_CONTROL = 6'h05;
   localparam logic [5:0] IDX_INPUT_SELECT = 6'h06;
   localparam logic [5:0] IDX_CONVERSION_COMMAND = 6'h08;
   localparam logic [5:0] IDX_EVENT_INPUT_CONTROL = 6'h09;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0A;
   localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0B;
   localparam logic [5:0] IDX_HALT_BEHAVIOUR_CONTROL = 6'h0C;
   localparam logic [5:0] IDX_WIDE_ACCESS_STAGING = 6'h0D;
   localparam logic [5:0] IDX_CONVERSION_RESULT = 6'h10;
   localparam logic [5:0] IDX_LOW_THRESHOLD = 6'h12;
   localparam logic [5:0] IDX_HIGH_THRESHOLD = 6'h14;
   localparam logic [5:0] IDX_CALIBRATION = 6'h16;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int ENABLE_BIT = 0;
   localparam int CONTINUOUS_MODE_BIT = 1;
   localparam int RESOLUTION_SELECT_BIT = 2;
   localparam int STANDBY_RUN_BIT = 7;
   localparam int CAPACITANCE_SELECT_BIT = 6;
   localparam int REFERENCE_SELECT_LSB = 4;
   localparam int DELAY_VARIATION_BIT = 4;
   localparam int STARTUP_DELAY_LSB = 5;
   localparam int RESULT_READY_BIT = 0;
   localparam int WINDOW_MATCH_BIT = 1;

   // ------------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [1:0] REF_INTERNAL = 2'h0;
   localparam logic [2:0] WINDOW_NONE = 3'h0;
   localparam logic [2:0] WINDOW_BELOW = 3'h1;
   localparam logic [2:0] WINDOW_ABOVE = 3'h2;
   localparam logic [2:0] WINDOW_INSIDE = 3'h3;
   localparam logic [2:0] WINDOW_OUTSIDE = 3'h4;

   // ------------------------------------------------------------------
   // timing: sampling lasts this many converter clocks plus the length field
   // ------------------------------------------------------------------
   localparam logic [8:0] SAMPLE_BASE_CYCLES = 9'h002;

   typedef enum logic [2:0] {IDLE, INIT_WAIT, SAMPLING, CONVERTING, GAP_WAIT} phase_t;

endpackage : adc_seq_pkg

// [dv/analog_core_model.sv]
/* behavioural analog core: answers each convert_start pulse with core_done
   and a fixed code; assumes the sequencer's clock and reset */
`timescale 1ns/1ns
`default_nettype none
module analog_core_model #(parameter logic [9:0] SAMPLE_CODE = 10'h155)
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // sequencer side
   input wire logic convert_start,
   output logic core_done,
   output logic [9:0] core_data
);
   logic [3:0] pipe;
   // done five clocks after the start; data toggles when not valid so a
   // sequencer that latches early sees the right code at most on alternate cycles
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pipe <= 4'h0;
         core_done <= 1'b0;
         core_data <= 10'h0;
      end else begin
         pipe <= {pipe[2:0], convert_start};
         core_done <= pipe[3];
         core_data <= pipe[3] ? SAMPLE_CODE : ~core_data;
      end
   end
endmodule : analog_core_model
`default_nettype wire

// [dv/adc_sequencer_control_test.sv]
/* self-checking bench: register table, refused start, accumulated run.
   assumes the APB slave and the core model share one clock */
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control_test
   import adc_seq_pkg::*;
;
   localparam logic [9:0] CODE = 10'h2A7;
   typedef struct packed {logic [5:0] i; logic [7:0] w; logic [7:0] r; logic e;} row_t;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, core_done, analog_enable, capacitance_select;
   logic convert_start, result_ready_event;
   logic sb = 1'b0, ev = 1'b0;
   logic [1:0] reference_select, irq;
   logic [4:0] sel;
   logic [9:0] core_data;
   int errors = 0, n_checks = 0, n_cs = 0, n_evt = 0;
   row_t rows [8];
   adc_sequencer_control adc_sequencer_control_inst (.clock(clock), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby_sleep(sb),
      .cpu_halted(1'b0), .deep_sleep_wake(1'b0), .start_event(ev),
      .analog_enable(analog_enable), .reference_select(reference_select),
      .capacitance_select(capacitance_select), .input_select(sel), .sample_active(),
      .convert_start(convert_start), .core_done(core_done), .core_data(core_data),
      .result_ready_event(result_ready_event), .irq_request(irq));
   analog_core_model #(.SAMPLE_CODE(CODE)) analog_core_model_inst (.clock(clock),
      .resetn(resetn), .convert_start(convert_start), .core_done(core_done),
      .core_data(core_data));
   always #50 clock = ~clock;
   // pulses stand one cycle, so the falling edge sees each exactly once
   always @(negedge clock) begin
      n_cs += (convert_start === 1'b1);
      n_evt += (result_ready_event === 1'b1);
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; the leading edge keeps back-to-back calls from
   // assigning psel twice in one time step
   task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
      int t;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clock);
      penable <= 1'b1;
      // the answer counts only at a rising edge that sees pready high
      for (t = 0; t < 20; t++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      if (t == 20) begin
         errors++;
         end_of_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   initial begin
      rows = '{'{IDX_CONTROL_ENABLE_MODE, 8'h84, 8'h84, 1'b0},
               '{IDX_ACCUMULATION_CONTROL, 8'h01, 8'h01, 1'b0},
               '{IDX_REFERENCE_CLOCK_CONTROL, 8'hE8, 8'h60, 1'b0},
               '{IDX_DELAY_CONTROL, 8'h10, 8'h10, 1'b0},
               '{IDX_WINDOW_MODE_CONTROL, 8'h04, 8'h04, 1'b0},
               '{IDX_INPUT_SELECT, 8'hFF, 8'h1F, 1'b0},
               '{IDX_IRQ_ENABLE, 8'h03, 8'h03, 1'b0},
               '{6'h07, 8'hFF, 8'h00, 1'b1}};
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      // reset value, write, read back, slave error only on the hole
      foreach (rows[k]) begin
         apb(1'b0, rows[k].i, 8'h00);
         chk(q, 32'h0);
         apb(1'b1, rows[k].i, rows[k].w);
         apb(1'b0, rows[k].i, 8'h00);
         chk(q, {24'h0, rows[k].r});
         chk({31'h0, e}, {31'h0, rows[k].e});
      end
      chk({24'h0, sel, reference_select, capacitance_select}, 32'hFD);
      apb(1'b1, IDX_CONVERSION_COMMAND, 8'h01);
      apb(1'b0, IDX_CONVERSION_COMMAND, 8'h00);
      chk(q, 32'h0);
      chk(n_cs, 32'h0);
      apb(1'b1, IDX_HIGH_THRESHOLD, 8'h10);
      apb(1'b1, IDX_CONTROL_ENABLE_MODE, 8'h85);
      apb(1'b1, IDX_CONVERSION_COMMAND, 8'h01);
      chk({31'h0, analog_enable}, 32'h1);
      apb(1'b0, IDX_CONVERSION_COMMAND, 8'h00);
      chk(q, 32'h1);
      for (int t = 0; t < 30 && q[0] === 1'b1; t++) apb(1'b0, IDX_CONVERSION_COMMAND, 8'h00);
      chk(q, 32'h0);
      chk(n_cs, 32'h2);
      chk(n_evt, 32'h1);
      apb(1'b0, IDX_IRQ_FLAGS, 8'h00);
      chk(q, 32'h3);
      chk({30'h0, irq}, 32'h3);
      apb(1'b0, IDX_CONVERSION_RESULT, 8'h00);
      chk(q, 32'(CODE[9:2]) << 1);
      apb(1'b0, IDX_IRQ_FLAGS, 8'h00);
      chk(q, 32'h0);
      chk({30'h0, irq}, 32'h0);
      apb(1'b0, IDX_DELAY_CONTROL, 8'h00);
      chk(q, 32'h12);
      // event-started continuous run, stopped by leaving continuous mode
      apb(1'b1, IDX_EVENT_INPUT_CONTROL, 8'h01);
      apb(1'b1, IDX_CONTROL_ENABLE_MODE, 8'h87);
      ev <= 1'b1;
      for (int t = 0; t < 400 && n_evt < 3; t++) @(posedge clock);
      chk(n_evt, 32'h3);
      apb(1'b0, IDX_CONVERSION_COMMAND, 8'h00);
      chk(q, 32'h1);
      apb(1'b1, IDX_CONTROL_ENABLE_MODE, 8'h85);
      for (int t = 0; t < 40 && q[0] === 1'b1; t++) apb(1'b0, IDX_CONVERSION_COMMAND, 8'h00);
      chk(q, 32'h0);
      chk(n_evt, 32'h4);
      // standby stops the converter only without the standby-run bit
      sb <= 1'b1;
      apb(1'b1, IDX_CONTROL_ENABLE_MODE, 8'h05);
      repeat (2) @(posedge clock);
      chk({31'h0, analog_enable}, 32'h0);
      apb(1'b1, IDX_CONTROL_ENABLE_MODE, 8'h85);
      repeat (2) @(posedge clock);
      chk({31'h0, analog_enable}, 32'h1);
      end_of_test();
   end
endmodule : adc_sequencer_control_test
`default_nettype wire
